//--- comparator_model.sv
// Purpose: comparator front end standing in for supply, line and fault sensing
// Assumes: supply in 0.1 V steps, line in volts, fault pin in millivolts
// Notes:   inhibit and reset levels are plain defaults, no hysteresis modelled

module comparator_model #(
	parameter int INHIBIT_DV = 40,
	parameter int RESET_DV   = 30
) (
	input  wire logic [15:0] supplyDv,
	input  wire logic [15:0] lineV,
	input  wire logic [15:0] faultMv,
	output logic             supplyAboveInhibit,
	output logic             supplyAboveOn,
	output logic             supplyBelowOff,
	output logic             supplyAboveOvp,
	output logic             supplyBelowReset,
	output logic             lineAboveStart,
	output logic             lineAboveStop,
	output logic             lineAboveDriveDisable,
	output logic             lineAboveRange,
	output logic             faultAboveUpper,
	output logic             faultBelowLower,
	output logic             faultAboveLowerExit
);
	assign supplyAboveInhibit    = supplyDv > INHIBIT_DV;
	assign supplyAboveOn         = supplyDv >= 170;
	assign supplyBelowOff        = supplyDv < 88;
	assign supplyAboveOvp        = supplyDv > 280;
	assign supplyBelowReset      = supplyDv < RESET_DV;
	assign lineAboveStart        = lineV > 111;
	assign lineAboveStop         = lineV > 101;
	assign lineAboveDriveDisable = lineV > 30;
	assign lineAboveRange        = lineV > 240;
	assign faultAboveUpper       = faultMv > 3000;
	assign faultBelowLower       = faultMv < 400;
	assign faultAboveLowerExit   = faultMv > 920;
endmodule // comparator_model

//--- qual_timer.sv
// Purpose: qualification timer, expires once run has held for LIMIT cycles
// Assumes: run and clear come from logic on the same clock
// Notes:   clear wins over run; output stays high while run holds

module qual_timer #(
	parameter int LIMIT = 16
) (
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic clear,
	input  wire logic run,
	output logic      expired
);

	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
	localparam logic [CW-1:0] ZERO_C  = '0;
	localparam logic [CW-1:0] ONE_C   = CW'(1);

	logic [CW-1:0] count_r;

	generate
		if (LIMIT < 1) begin : g_bad
			$error("qual_timer LIMIT must be at least one");
		end
	endgenerate

	// saturating count, so a long assertion never wraps back to idle
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			count_r <= ZERO_C;
		end else if (clear || !run) begin
			count_r <= ZERO_C;
		end else if (count_r != LIMIT_C) begin
			count_r <= count_r + ONE_C;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			expired <= 1'b0;
		end else begin
			expired <= run && !clear && (count_r == LIMIT_C);
		end
	end

endmodule // qual_timer

//--- supervisor_pkg.sv
// Purpose: shared constants for the supply, line and fault supervisor
// Assumes: 200 MHz reference clock, comparator decisions arrive as single bits
// Notes:   times are kept in their printed unit, cycle counts derive from them

package supervisor_pkg;

	// ----------------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------------
	localparam int CLK_FREQ_MHZ        = 200;
	localparam int BROWNOUT_TIME_US    = 54000;
	localparam int RAISE_RANGE_TIME_US = 300;
	localparam int LOWER_RANGE_TIME_US = 54000;
	localparam int FAULT_BLANK_TIME_US = 30;

	localparam int BROWNOUT_CYCLES    = BROWNOUT_TIME_US * CLK_FREQ_MHZ;
	localparam int RAISE_RANGE_CYCLES = RAISE_RANGE_TIME_US * CLK_FREQ_MHZ;
	localparam int LOWER_RANGE_CYCLES = LOWER_RANGE_TIME_US * CLK_FREQ_MHZ;
	localparam int FAULT_BLANK_CYCLES = FAULT_BLANK_TIME_US * CLK_FREQ_MHZ;

	// ----------------------------------------------------------------------
	// behaviour constants
	// ----------------------------------------------------------------------
	localparam logic [1:0] HICCUP_SKIPS   = 2'h3;
	localparam logic [1:0] HICCUP_NONE    = 2'h0;
	localparam int         ONTIME_DIVISOR = 3;

	// ----------------------------------------------------------------------
	// synchroniser bit positions
	// ----------------------------------------------------------------------
	localparam int SYNC_WIDTH       = 13;
	localparam int SY_INHIBIT       = 0;
	localparam int SY_SUPPLY_ON     = 1;
	localparam int SY_SUPPLY_OFF    = 2;
	localparam int SY_SUPPLY_OVP    = 3;
	localparam int SY_SUPPLY_RESET  = 4;
	localparam int SY_LINE_START    = 5;
	localparam int SY_LINE_STOP     = 6;
	localparam int SY_LINE_DRIVE    = 7;
	localparam int SY_LINE_RANGE    = 8;
	localparam int SY_FAULT_UPPER   = 9;
	localparam int SY_FAULT_LOWER   = 10;
	localparam int SY_FAULT_EXIT    = 11;
	localparam int SY_AUTO_RECOVER  = 12;

	typedef enum logic [3:0] {
		ST_CHARGE = 4'h1,
		ST_WAIT   = 4'h2,
		ST_RUN    = 4'h4,
		ST_LATCH  = 4'h8
	} supState_t;

endpackage

//--- supervisor_sva.sv
// Purpose: port-level checks for the supply, line and fault supervisor
// Assumes: single clock domain, asynchronous active-high reset
// Notes:   qualification counters count raw pin levels, so sync delay only adds slack

module supervisor_checker #(
	parameter int RAISE_RANGE_TICKS = 20,
	parameter int LOWER_RANGE_TICKS = 40,
	parameter int FAULT_BLANK_TICKS = 8
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic supplyAboveOn,
	input wire logic supplyBelowOff,
	input wire logic lineAboveStart,
	input wire logic lineAboveRange,
	input wire logic faultAboveUpper,
	input wire logic startupEnable,
	input wire logic startupCurrentFull,
	input wire logic startupCurrentReduced,
	input wire logic pfcEnable,
	input wire logic flybackEnable,
	input wire logic highLineMode,
	input wire logic onTimeThird,
	input wire logic faultClampZero,
	input wire logic latchedOff,
	input wire logic hiccupActive
);
	logic [15:0] rangeHigh;
	logic [15:0] rangeLow;
	logic [15:0] upperHigh;
	logic        supplyReached_r;

	// ----------------------------------------------------------------------
	// run lengths of the raw comparator levels
	// ----------------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rangeHigh <= 16'h0;
			rangeLow  <= 16'h0;
			upperHigh <= 16'h0;
		end else begin
			rangeHigh <= lineAboveRange ? rangeHigh + 16'h1 : 16'h0;
			rangeLow  <= lineAboveRange ? 16'h0 : rangeLow + 16'h1;
			upperHigh <= faultAboveUpper ? upperHigh + 16'h1 : 16'h0;
		end
	end

	// turn-on is an event, the supply may sag below it and keep running
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			supplyReached_r <= 1'b0;
		end else if (supplyAboveOn) begin
			supplyReached_r <= 1'b1;
		end else if (supplyBelowOff) begin
			supplyReached_r <= 1'b0;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	startup_pair_a: assert property (
		(startupCurrentFull | startupCurrentReduced) |->
		startupEnable && !(startupCurrentFull && startupCurrentReduced))
		else $error("startup current setting without startup or both set");
	startup_exclusive_a: assert property (
		!(startupEnable && flybackEnable))
		else $error("startup source on while flyback runs");
	flyback_cause_a: assert property (
		$rose(flybackEnable) |-> $past(supplyReached_r, 2) && $past(lineAboveStart, 2))
		else $error("flyback enabled without supply on and line ok");
	latch_outputs_a: assert property (
		latchedOff |-> faultClampZero && !pfcEnable && !flybackEnable)
		else $error("latched state with clamp released or stage running");
	ontime_third_a: assert property (
		onTimeThird == highLineMode)
		else $error("on-time cut differs from line mode");
	raise_qual_a: assert property (
		$rose(highLineMode) |-> rangeHigh >= RAISE_RANGE_TICKS)
		else $error("high line selected before qualification");
	lower_qual_a: assert property (
		$fell(highLineMode) |-> rangeLow >= LOWER_RANGE_TICKS)
		else $error("low line selected before timer expiry");
	upper_blank_a: assert property (
		$rose(hiccupActive) |-> upperHigh >= FAULT_BLANK_TICKS)
		else $error("upper fault confirmed before blanking");
	upper_gate_a: assert property (
		$rose(hiccupActive) |-> $past(flybackEnable, 2))
		else $error("upper fault acted on with flyback off");
endmodule // supervisor_checker

//--- supply_line_fault_supervisor.sv
// Purpose: startup source, converter enables, line range and fault handling
// Assumes: all comparator inputs are asynchronous; softStartActive is same-clock
// Notes:   timers are parameters so a simulation can shorten them

module supply_line_fault_supervisor
	import supervisor_pkg::*;
#(
	parameter int BROWNOUT_TICKS    = BROWNOUT_CYCLES,
	parameter int RAISE_RANGE_TICKS = RAISE_RANGE_CYCLES,
	parameter int LOWER_RANGE_TICKS = LOWER_RANGE_CYCLES,
	parameter int FAULT_BLANK_TICKS = FAULT_BLANK_CYCLES
) (
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic supplyAboveInhibit,
	input  wire logic supplyAboveOn,
	input  wire logic supplyBelowOff,
	input  wire logic supplyAboveOvp,
	input  wire logic supplyBelowReset,
	input  wire logic lineAboveStart,
	input  wire logic lineAboveStop,
	input  wire logic lineAboveDriveDisable,
	input  wire logic lineAboveRange,
	input  wire logic faultAboveUpper,
	input  wire logic faultBelowLower,
	input  wire logic faultAboveLowerExit,
	input  wire logic otpAutoRecover,
	input  wire logic softStartActive,
	output logic      startupEnable,
	output logic      startupCurrentFull,
	output logic      startupCurrentReduced,
	output logic      pfcEnable,
	output logic      flybackEnable,
	output logic      highLineMode,
	output logic      onTimeThird,
	output logic      faultPullupSource,
	output logic      faultClampZero,
	output logic      latchedOff,
	output logic      hiccupActive
);

	// ----------------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------------
	generate
		if (BROWNOUT_TICKS < 1 || RAISE_RANGE_TICKS < 1 ||
		    LOWER_RANGE_TICKS < 1 || FAULT_BLANK_TICKS < 1) begin : g_bad
			$error("supervisor timer counts must be at least one");
		end
	endgenerate

	// ----------------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------------
	logic [SYNC_WIDTH-1:0] syncA_r;
	logic [SYNC_WIDTH-1:0] syncB_r;
	logic [SYNC_WIDTH-1:0] pins;

	assign pins[SY_INHIBIT]      = supplyAboveInhibit;
	assign pins[SY_SUPPLY_ON]    = supplyAboveOn;
	assign pins[SY_SUPPLY_OFF]   = supplyBelowOff;
	assign pins[SY_SUPPLY_OVP]   = supplyAboveOvp;
	assign pins[SY_SUPPLY_RESET] = supplyBelowReset;
	assign pins[SY_LINE_START]   = lineAboveStart;
	assign pins[SY_LINE_STOP]    = lineAboveStop;
	assign pins[SY_LINE_DRIVE]   = lineAboveDriveDisable;
	assign pins[SY_LINE_RANGE]   = lineAboveRange;
	assign pins[SY_FAULT_UPPER]  = faultAboveUpper;
	assign pins[SY_FAULT_LOWER]  = faultBelowLower;
	assign pins[SY_FAULT_EXIT]   = faultAboveLowerExit;
	assign pins[SY_AUTO_RECOVER] = otpAutoRecover;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			syncA_r <= '0;
			syncB_r <= '0;
		end else begin
			syncA_r <= pins;
			syncB_r <= syncA_r;
		end
	end

	logic inhibitOk;
	logic supplyOn;
	logic supplyOff;
	logic supplyOvp;
	logic supplyRst;
	logic lineStart;
	logic lineStop;
	logic lineDrive;
	logic lineRange;
	logic faultUpper;
	logic faultLower;
	logic faultExit;
	logic autoRecover;

	assign inhibitOk   = syncB_r[SY_INHIBIT];
	assign supplyOn    = syncB_r[SY_SUPPLY_ON];
	assign supplyOff   = syncB_r[SY_SUPPLY_OFF];
	assign supplyOvp   = syncB_r[SY_SUPPLY_OVP];
	assign supplyRst   = syncB_r[SY_SUPPLY_RESET];
	assign lineStart   = syncB_r[SY_LINE_START];
	assign lineStop    = syncB_r[SY_LINE_STOP];
	assign lineDrive   = syncB_r[SY_LINE_DRIVE];
	assign lineRange   = syncB_r[SY_LINE_RANGE];
	assign faultUpper  = syncB_r[SY_FAULT_UPPER];
	assign faultLower  = syncB_r[SY_FAULT_LOWER];
	assign faultExit   = syncB_r[SY_FAULT_EXIT];
	assign autoRecover = syncB_r[SY_AUTO_RECOVER];

	// ----------------------------------------------------------------------
	// line start edge and brown-out
	// ----------------------------------------------------------------------
	logic lineStartPrev_r;
	logic lineStartRise;
	logic brownoutExpired;
	logic brownoutHit;
	logic lineOk_r;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			lineStartPrev_r <= 1'b0;
		end else begin
			lineStartPrev_r <= lineStart;
		end
	end

	assign lineStartRise = lineStart && !lineStartPrev_r;

	qual_timer #(
		.LIMIT (BROWNOUT_TICKS)
	) brownoutTimer (
		.clock   (clock),
		.reset   (reset),
		.clear   (lineStop),
		.run     (!lineStop),
		.expired (brownoutExpired)
	);

	// switching stops only once the line has sagged to a low energy point
	assign brownoutHit = brownoutExpired && !lineDrive;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			lineOk_r <= 1'b0;
		end else if (lineStart) begin
			lineOk_r <= 1'b1;
		end else if (brownoutHit) begin
			lineOk_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// line range detector
	// ----------------------------------------------------------------------
	logic highLine_r;
	logic raiseInhibit_r;
	logic raiseExpired;
	logic lowerExpired;

	qual_timer #(
		.LIMIT (RAISE_RANGE_TICKS)
	) raiseRangeTimer (
		.clock   (clock),
		.reset   (reset),
		.clear   (raiseInhibit_r || highLine_r),
		.run     (lineRange),
		.expired (raiseExpired)
	);

	qual_timer #(
		.LIMIT (LOWER_RANGE_TICKS)
	) lowerRangeTimer (
		.clock   (clock),
		.reset   (reset),
		.clear   (!highLine_r),
		.run     (!lineRange),
		.expired (lowerExpired)
	);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			highLine_r <= 1'b0;
		end else if (!highLine_r && raiseExpired) begin
			highLine_r <= 1'b1;
		end else if (highLine_r && lowerExpired) begin
			highLine_r <= 1'b0;
		end
	end

	// blocks noise from toggling the range back until a stop crossing is seen
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			raiseInhibit_r <= 1'b0;
		end else if (highLine_r && lowerExpired) begin
			raiseInhibit_r <= 1'b1;
		end else if (!lineStop) begin
			raiseInhibit_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// fault input qualification
	// ----------------------------------------------------------------------
	logic upperConfirmed;
	logic lowerConfirmed;
	logic flyback_r;

	qual_timer #(
		.LIMIT (FAULT_BLANK_TICKS)
	) upperBlank (
		.clock   (clock),
		.reset   (reset),
		.clear   (!flyback_r),
		.run     (faultUpper),
		.expired (upperConfirmed)
	);

	qual_timer #(
		.LIMIT (FAULT_BLANK_TICKS)
	) lowerBlank (
		.clock   (clock),
		.reset   (reset),
		.clear   (softStartActive),
		.run     (faultLower),
		.expired (lowerConfirmed)
	);

	// ----------------------------------------------------------------------
	// sequencing state machine
	// ----------------------------------------------------------------------
	supState_t  state_r;
	supState_t  state_nxt;
	logic [1:0] hiccup_r;
	logic       otpPending_r;
	logic       supplyOvpTrip;
	logic       otpTrip;
	logic       latchClear;
	logic       restartOk;

	assign supplyOvpTrip = flyback_r && supplyOvp;
	assign otpTrip       = (state_r == ST_RUN) && lowerConfirmed;
	assign latchClear    = brownoutHit || supplyRst;
	assign restartOk     = !otpPending_r && (hiccup_r == HICCUP_NONE);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_CHARGE: begin
				if (supplyOn) begin
					state_nxt = restartOk ? ST_RUN : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (supplyOff || lineStartRise) begin
					state_nxt = ST_CHARGE;
				end
			end
			ST_RUN: begin
				if (supplyOvpTrip) begin
					state_nxt = ST_LATCH;
				end else if (otpTrip && !autoRecover) begin
					state_nxt = ST_LATCH;
				end else if (otpTrip || upperConfirmed) begin
					state_nxt = ST_WAIT;
				end else if (supplyOff) begin
					state_nxt = ST_CHARGE;
				end
			end
			ST_LATCH: begin
				if (latchClear) begin
					state_nxt = ST_CHARGE;
				end
			end
			default: begin
				state_nxt = ST_CHARGE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_r <= ST_CHARGE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// a hiccup skips three supply cycles before the next attempt
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			hiccup_r <= HICCUP_NONE;
		end else if (state_r == ST_RUN && upperConfirmed && !supplyOvpTrip) begin
			hiccup_r <= HICCUP_SKIPS;
		end else if (state_r == ST_CHARGE && supplyOn && hiccup_r != HICCUP_NONE) begin
			hiccup_r <= hiccup_r - 2'h1;
		end else if (state_r == ST_LATCH) begin
			hiccup_r <= HICCUP_NONE;
		end
	end

	// set wins over the exit clear when both land together
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			otpPending_r <= 1'b0;
		end else if (otpTrip && autoRecover) begin
			otpPending_r <= 1'b1;
		end else if (faultExit || state_r == ST_LATCH) begin
			otpPending_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------------
	logic runNext;
	logic chargeNext;

	assign runNext    = (state_nxt == ST_RUN);
	assign chargeNext = (state_nxt == ST_CHARGE);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			startupEnable         <= 1'b1;
			startupCurrentFull    <= 1'b0;
			startupCurrentReduced <= 1'b1;
		end else begin
			startupEnable         <= chargeNext;
			startupCurrentFull    <= chargeNext && inhibitOk;
			startupCurrentReduced <= chargeNext && !inhibitOk;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pfcEnable <= 1'b0;
			flyback_r <= 1'b0;
		end else begin
			pfcEnable <= runNext && lineOk_r && !brownoutHit;
			flyback_r <= runNext && lineOk_r && !brownoutHit;
		end
	end

	assign flybackEnable = flyback_r;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			highLineMode <= 1'b0;
			onTimeThird  <= 1'b0;
		end else begin
			highLineMode <= highLine_r;
			onTimeThird  <= highLine_r;
		end
	end

	// pull-up stays on through a pending fault for temperature hysteresis
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			faultPullupSource <= 1'b0;
		end else begin
			faultPullupSource <= runNext || otpPending_r;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			faultClampZero <= 1'b0;
			latchedOff     <= 1'b0;
			hiccupActive   <= 1'b0;
		end else begin
			faultClampZero <= (state_nxt == ST_LATCH);
			latchedOff     <= (state_nxt == ST_LATCH);
			hiccupActive   <= (hiccup_r != HICCUP_NONE);
		end
	end

endmodule // supply_line_fault_supervisor

//--- supply_line_fault_supervisor_bench.sv
// Purpose: directed bench for the supply, line and fault supervisor
// Assumes: shortened timers, comparator model between bench levels and design
// Notes:   every level driver waits five edges after its change to cover sync delay

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
	$display("unexpected %s expected %b seen %b", nm, ex, got); end end

module supply_line_fault_supervisor_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int BO = 40;
	localparam int RR = 20;
	localparam int LR = 40;
	localparam int FB = 8;

	logic        clock, reset, otpAutoRecover, softStartActive;
	logic [15:0] supplyDv, lineV, faultMv;
	logic        supplyAboveInhibit, supplyAboveOn, supplyBelowOff, supplyAboveOvp;
	logic        supplyBelowReset, lineAboveStart, lineAboveStop, lineAboveDriveDisable;
	logic        lineAboveRange, faultAboveUpper, faultBelowLower, faultAboveLowerExit;
	logic        startupEnable, startupCurrentFull, startupCurrentReduced, pfcEnable;
	logic        flybackEnable, highLineMode, onTimeThird, faultPullupSource;
	logic        faultClampZero, latchedOff, hiccupActive;
	int          miscompares, comparisons;

	comparator_model comparator_model_inst (.supplyDv, .lineV, .faultMv,
		.supplyAboveInhibit, .supplyAboveOn, .supplyBelowOff, .supplyAboveOvp,
		.supplyBelowReset, .lineAboveStart, .lineAboveStop, .lineAboveDriveDisable,
		.lineAboveRange, .faultAboveUpper, .faultBelowLower, .faultAboveLowerExit);

	supply_line_fault_supervisor #(.BROWNOUT_TICKS(BO), .RAISE_RANGE_TICKS(RR),
		.LOWER_RANGE_TICKS(LR), .FAULT_BLANK_TICKS(FB)) supply_line_fault_supervisor_inst (
		.clock, .reset, .supplyAboveInhibit, .supplyAboveOn, .supplyBelowOff,
		.supplyAboveOvp, .supplyBelowReset, .lineAboveStart, .lineAboveStop,
		.lineAboveDriveDisable, .lineAboveRange, .faultAboveUpper, .faultBelowLower,
		.faultAboveLowerExit, .otpAutoRecover, .softStartActive, .startupEnable,
		.startupCurrentFull, .startupCurrentReduced, .pfcEnable, .flybackEnable,
		.highLineMode, .onTimeThird, .faultPullupSource, .faultClampZero, .latchedOff,
		.hiccupActive);

	always #2.5 clock = ~clock;

	// ----------------------------------------------------------------------
	// level drivers and checks
	// ----------------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic sup(input int v); @(posedge clock); supplyDv <= v[15:0]; cyc(5); endtask
	task automatic lin(input int v); @(posedge clock); lineV <= v[15:0]; cyc(5); endtask
	task automatic flt(input int v); @(posedge clock); faultMv <= v[15:0]; cyc(5); endtask
	task automatic stages(input logic su, input logic on);
		`CHK("startupEnable", su, startupEnable)
		`CHK("pfcEnable", on, pfcEnable)
		`CHK("flybackEnable", on, flybackEnable)
	endtask
	task automatic stop_test();
		if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		reset = 1'b1;
		otpAutoRecover = 1'b0;
		softStartActive = 1'b0;
		supplyDv = 16'h0;
		lineV = 16'h0;
		faultMv = 16'h3e8;
		miscompares = 0;
		comparisons = 0;
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		cyc(4);
		`CHK("startupCurrentReduced", 1'b1, startupCurrentReduced)
		`CHK("highLineMode", 1'b0, highLineMode)
		sup(50);
		`CHK("startupCurrentFull", 1'b1, startupCurrentFull)
		sup(170);
		stages(1'b0, 1'b0);
		sup(100);
		lin(120);
		sup(170);
		stages(1'b0, 1'b1);
		sup(80);
		stages(1'b1, 1'b0);
		sup(170);
		// ------------------------------------------------------------------
		// line range selection
		// ------------------------------------------------------------------
		lin(250);
		lin(120);
		`CHK("highLineMode", 1'b0, highLineMode)
		lin(250);
		cyc(RR + 8);
		`CHK("highLineMode", 1'b1, highLineMode)
		`CHK("onTimeThird", 1'b1, onTimeThird)
		lin(120);
		cyc(LR + 8);
		`CHK("highLineMode", 1'b0, highLineMode)
		lin(250);
		cyc(RR + 8);
		`CHK("highLineMode", 1'b0, highLineMode)
		lin(90);
		stages(1'b0, 1'b1);
		lin(250);
		cyc(RR + 8);
		`CHK("highLineMode", 1'b1, highLineMode)
		lin(120);
		cyc(LR + 8);
		// ------------------------------------------------------------------
		// upper fault, blanking and triple hiccup
		// ------------------------------------------------------------------
		flt(3500);
		flt(1000);
		`CHK("hiccupActive", 1'b0, hiccupActive)
		flt(3500);
		cyc(FB + 8);
		`CHK("hiccupActive", 1'b1, hiccupActive)
		stages(1'b0, 1'b0);
		// supply parked between off and on, so charging holds after the line edge
		sup(100);
		flt(1000);
		lin(20);
		lin(120);
		`CHK("startupEnable", 1'b1, startupEnable)
		for (int i = 0; i < 4; i++) begin
			sup(80);
			sup(170);
			`CHK("flybackEnable", i == 3, flybackEnable)
		end
		// ------------------------------------------------------------------
		// brown-out
		// ------------------------------------------------------------------
		lin(20);
		cyc(15);
		stages(1'b0, 1'b1);
		cyc(BO);
		stages(1'b0, 1'b0);
		lin(120);
		sup(80);
		sup(170);
		stages(1'b0, 1'b1);
		// ------------------------------------------------------------------
		// supply overvoltage latch
		// ------------------------------------------------------------------
		sup(290);
		`CHK("latchedOff", 1'b1, latchedOff)
		`CHK("faultClampZero", 1'b1, faultClampZero)
		sup(170);
		stages(1'b0, 1'b0);
		sup(20);
		`CHK("latchedOff", 1'b0, latchedOff)
		sup(170);
		stages(1'b0, 1'b1);
		// ------------------------------------------------------------------
		// overtemperature, both options
		// ------------------------------------------------------------------
		@(posedge clock);
		otpAutoRecover <= 1'b1;
		softStartActive <= 1'b1;
		flt(200);
		cyc(FB + 8);
		`CHK("flybackEnable", 1'b1, flybackEnable)
		@(posedge clock);
		softStartActive <= 1'b0;
		cyc(FB + 8);
		stages(1'b0, 1'b0);
		`CHK("latchedOff", 1'b0, latchedOff)
		sup(80);
		`CHK("faultPullupSource", 1'b1, faultPullupSource)
		flt(1000);
		sup(170);
		stages(1'b0, 1'b1);
		@(posedge clock);
		otpAutoRecover <= 1'b0;
		flt(200);
		cyc(FB + 8);
		`CHK("latchedOff", 1'b1, latchedOff)
		flt(1000);
		lin(20);
		cyc(BO + 8);
		`CHK("latchedOff", 1'b0, latchedOff)
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		stop_test();
	end
endmodule // supply_line_fault_supervisor_bench

bind supply_line_fault_supervisor supervisor_checker #(.RAISE_RANGE_TICKS(RAISE_RANGE_TICKS),
	.LOWER_RANGE_TICKS(LOWER_RANGE_TICKS), .FAULT_BLANK_TICKS(FAULT_BLANK_TICKS))
	supervisor_checker_inst (.clock, .reset, .supplyAboveOn, .supplyBelowOff, .lineAboveStart,
	.lineAboveRange, .faultAboveUpper, .startupEnable, .startupCurrentFull,
	.startupCurrentReduced, .pfcEnable, .flybackEnable, .highLineMode, .onTimeThird,
	.faultClampZero, .latchedOff, .hiccupActive);
